// file: ldrcs_pkg.sv
// constants, register map and state types for the lcd reset/config block
package ldrcs_pkg;
  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ_DEF = 40000000;
  localparam int unsigned OSC_HZ_DEF = 32000;
  localparam int unsigned FRAME_LO_HZ = 80;
  localparam int unsigned FRAME_HI_HZ = 160;
  localparam int unsigned BLINK_DIV_DEF = 16384;
  localparam int unsigned QUARTER_COMMONS = 4;
  localparam int unsigned EIGHTH_COMMONS = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DRIVE = 8'h00;
  localparam logic [7:0] REG_SYSMODE = 8'h04;
  localparam logic [7:0] REG_FRAME = 8'h08;
  localparam logic [7:0] REG_BLINK = 8'h0c;
  localparam logic [7:0] REG_VADJ = 8'h10;
  localparam logic [7:0] REG_ADDR = 8'h14;
  localparam logic [7:0] REG_DATA = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned DRV_DUTY8_BIT = 0;
  localparam int unsigned DRV_BIAS4_BIT = 1;
  localparam int unsigned SYS_OSC_BIT = 0;
  localparam int unsigned SYS_BIAS_BIT = 1;
  localparam int unsigned SYS_DISP_BIT = 2;
  localparam int unsigned FRM_HI_BIT = 0;
  localparam int unsigned VADJ_EN_BIT = 4;
  localparam int unsigned VADJ_PIN_BIT = 5;
  localparam int unsigned VADJ_DET_BIT = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_DUTY8 = 1'b0;
  localparam logic RST_BIAS4 = 1'b0;
  localparam logic RST_OSC = 1'b0;
  localparam logic RST_BIASGEN = 1'b0;
  localparam logic RST_DISP = 1'b0;
  localparam logic RST_VADJ_EN = 1'b1;
  localparam logic RST_PIN_SUPPLY = 1'b0;
  localparam logic RST_DETECT = 1'b0;
  localparam logic RST_FRAME_HI = 1'b0;
  localparam logic [1:0] RST_BLINK = 2'h0;
  localparam logic [3:0] RST_VADJ_CODE = 4'h0;

  // ----------------------------------------------------------------
  // drive levels, in bias steps above ground
  // ----------------------------------------------------------------
  localparam logic [2:0] LVL_GND = 3'h0;
  localparam logic [2:0] LVL_ONE = 3'h1;
  localparam logic [2:0] LVL_TWO = 3'h2;
  localparam logic [2:0] LVL_TOP3 = 3'h3;
  localparam logic [2:0] LVL_TOP4 = 3'h4;

  typedef enum logic [0:0] {
    DRV_HOLD = 1'b0,
    DRV_RUN = 1'b1
  } ldrcs_drv_t;
endpackage

// file: ldrcs_top.sv
// lcd driver configuration state, power-on defaults and drive sequencing
// Behaviour
// - internal reset defines all state at power-up
// - outputs held at supply level until enabled
// - reset drive mode quarter duty, third bias
// - oscillator and bias generator off after reset
// - display off after reset
// - voltage adjustment enabled after reset
// - shared pin defaults to segment function
// - supply pin detection switch open after reset
// - frame rate defaults to lower rate
// - blinking off after reset
// - exactly two frame rates selectable
// - third/quarter bias, quarter/eighth duty selectable
// - 20x4 or 16x8 patterns by duty
// - four pins commons 4-7 or segments 0-3
// - display address auto-increments per byte
// - sixteen voltage steps from four-bit code
// - all timing from internal 32 kHz oscillator
// - blink modes off, 2, 1, 0.5 Hz
// - voltage code resets to zero
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module ldrcs_top
  import ldrcs_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF,
  parameter int unsigned OSC_HZ = OSC_HZ_DEF,
  parameter int unsigned BLINK_DIV = BLINK_DIV_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [11:0] commonOutputsLow,
  output logic [11:0] sharedCommonSegmentOutputs,
  output logic [47:0] segmentOutputsFixed,
  output logic [3:0] voltageAdjustCode,
  output logic voltageAdjustEnable,
  output logic lcdSupplyPinMode,
  output logic detectSwitchClosed,
  output logic biasGenEnable,
  output logic oscRunning
);
  // ----------------------------------------------------------------
  // derived counts and parameter checks
  // ----------------------------------------------------------------
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int unsigned PHASE_TICKS = OSC_HZ / (FRAME_LO_HZ * QUARTER_COMMONS);
  localparam int unsigned BLINK_LOG = $clog2(BLINK_DIV);
  localparam int unsigned BLINK_W = BLINK_LOG + 2;
  localparam int unsigned OSC_W = $clog2(OSC_DIV + 1);
  localparam int unsigned PH_W = $clog2(PHASE_TICKS + 1);

  generate
    if (OSC_DIV < 2 || PHASE_TICKS < 4 || BLINK_DIV < 4 ||
        (1 << BLINK_LOG) != BLINK_DIV || FRAME_HI_HZ != 2 * FRAME_LO_HZ) begin : g_bad
      $error("ldrcs_top: unsupported clock, oscillator or blink divider");
    end
  endgenerate
  // ----------------------------------------------------------------
  // configuration flops
  // ----------------------------------------------------------------
  logic duty8_q, bias4_q, oscEn_q, biasEn_q, dispOn_q, vadjEn_q;
  logic pinSupply_q, detect_q, frameHi_q;
  logic [1:0] blinkMode_q;
  logic [3:0] vadjCode_q, addr_q;
  logic [7:0] dispRam_q [16];
  logic ack_q;
  logic [31:0] rdat_q;
  logic reqTake, wrDone, rdDone;
  // taken when strobe arrives, completed on the acked edge
  assign reqTake = wb_cyc_i && wb_stb_i && !ack_q;
  assign wrDone = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
  assign rdDone = wb_cyc_i && wb_stb_i && ack_q && !wb_we_i;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      duty8_q <= RST_DUTY8;
      bias4_q <= RST_BIAS4;
      oscEn_q <= RST_OSC;
      biasEn_q <= RST_BIASGEN;
      dispOn_q <= RST_DISP;
      vadjEn_q <= RST_VADJ_EN;
      pinSupply_q <= RST_PIN_SUPPLY;
      detect_q <= RST_DETECT;
      frameHi_q <= RST_FRAME_HI;
      blinkMode_q <= RST_BLINK;
      vadjCode_q <= RST_VADJ_CODE;
    end else if (wrDone) begin
      case (wb_adr_i)
        REG_DRIVE: begin
          duty8_q <= wb_dat_i[DRV_DUTY8_BIT];
          bias4_q <= wb_dat_i[DRV_BIAS4_BIT];
        end
        REG_SYSMODE: begin
          oscEn_q <= wb_dat_i[SYS_OSC_BIT];
          biasEn_q <= wb_dat_i[SYS_BIAS_BIT];
          dispOn_q <= wb_dat_i[SYS_DISP_BIT];
        end
        REG_FRAME: frameHi_q <= wb_dat_i[FRM_HI_BIT];
        REG_BLINK: blinkMode_q <= wb_dat_i[1:0];
        REG_VADJ: begin
          vadjCode_q <= wb_dat_i[3:0];
          vadjEn_q <= wb_dat_i[VADJ_EN_BIT];
          pinSupply_q <= wb_dat_i[VADJ_PIN_BIT];
          detect_q <= wb_dat_i[VADJ_DET_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // display store and address pointer
  // ----------------------------------------------------------------
  // sixteen bytes; cleared so no stale pattern shows
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        dispRam_q[i] <= 8'h00;
      end
    end else if (wrDone && wb_adr_i == REG_DATA) begin
      dispRam_q[addr_q] <= wb_dat_i[7:0];
    end
  end
  // pointer advances after each data byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q <= 4'h0;
    end else if (wrDone && wb_adr_i == REG_ADDR) begin
      addr_q <= wb_dat_i[3:0];
    end else if ((wrDone || rdDone) && wb_adr_i == REG_DATA) begin
      addr_q <= addr_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after the strobe is seen
  // ----------------------------------------------------------------
  logic [2:0] phase_q;
  logic blinkBlank, frameInv_q;
  ldrcs_drv_t drv_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= reqTake;
    end
  end
  // read data captured at the taking edge, unmapped reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdat_q <= 32'h0000_0000;
    end else if (reqTake) begin
      rdat_q <= 32'h0000_0000;
      case (wb_adr_i)
        REG_DRIVE: rdat_q[1:0] <= {bias4_q, duty8_q};
        REG_SYSMODE: rdat_q[2:0] <= {dispOn_q, biasEn_q, oscEn_q};
        REG_FRAME: rdat_q[0] <= frameHi_q;
        REG_BLINK: rdat_q[1:0] <= blinkMode_q;
        REG_VADJ: rdat_q[6:0] <= {detect_q, pinSupply_q, vadjEn_q, vadjCode_q};
        REG_ADDR: rdat_q[3:0] <= addr_q;
        REG_DATA: rdat_q[7:0] <= dispRam_q[addr_q];
        REG_STATUS: rdat_q[5:0] <= {drv_q, blinkBlank, frameInv_q, phase_q};
        default: begin
        end
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  // ----------------------------------------------------------------
  // oscillator tick, frame and blink dividers
  // ----------------------------------------------------------------
  logic [OSC_W-1:0] oscCnt_q;
  logic [PH_W-1:0] phCnt_q, phLen;
  logic [BLINK_W-1:0] blinkCnt_q;
  logic oscTick, phaseEnd;
  logic [2:0] lastPhase;
  // tick stands in for the 32 kHz oscillator
  always_ff @(posedge clk) begin
    if (sys_rst || !oscEn_q) begin
      oscCnt_q <= '0;
    end else if (oscCnt_q == OSC_W'(OSC_DIV - 1)) begin
      oscCnt_q <= '0;
    end else begin
      oscCnt_q <= oscCnt_q + OSC_W'(1);
    end
  end
  assign oscTick = oscEn_q && (oscCnt_q == OSC_W'(OSC_DIV - 1));
  // fewer ticks per phase for eighth duty and the high rate
  assign phLen = PH_W'(PHASE_TICKS >> (32'(duty8_q) + 32'(frameHi_q)));
  assign lastPhase = duty8_q ? 3'(EIGHTH_COMMONS - 1) : 3'(QUARTER_COMMONS - 1);
  assign phaseEnd = oscTick && (phCnt_q == phLen - PH_W'(1));
  // dividers held in reset while oscillator off
  always_ff @(posedge clk) begin
    if (sys_rst || !oscEn_q) begin
      phCnt_q <= '0;
      phase_q <= 3'h0;
      frameInv_q <= 1'b0;
    end else if (phaseEnd) begin
      phCnt_q <= '0;
      // duty change mid-frame lands safely via the >= compare
      if (phase_q >= lastPhase) begin
        phase_q <= 3'h0;
        frameInv_q <= !frameInv_q;
      end else begin
        phase_q <= phase_q + 3'h1;
      end
    end else if (oscTick) begin
      phCnt_q <= phCnt_q + PH_W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst || !oscEn_q) begin
      blinkCnt_q <= '0;
    end else if (oscTick) begin
      blinkCnt_q <= blinkCnt_q + BLINK_W'(1);
    end
  end
  // second half of each blink period is blank
  always_comb begin
    case (blinkMode_q)
      2'h1: blinkBlank = blinkCnt_q[BLINK_LOG-1];
      2'h2: blinkBlank = blinkCnt_q[BLINK_LOG];
      2'h3: blinkBlank = blinkCnt_q[BLINK_LOG+1];
      default: blinkBlank = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // drive sequencing: hold at supply level until fully enabled
  // ----------------------------------------------------------------
  // run only with oscillator, bias and display on
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drv_q <= DRV_HOLD;
    end else begin
      case (drv_q)
        DRV_HOLD: if (oscEn_q && biasEn_q && dispOn_q) drv_q <= DRV_RUN;
        DRV_RUN: if (!(oscEn_q && biasEn_q && dispOn_q)) drv_q <= DRV_HOLD;
        default: drv_q <= DRV_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // waveform levels
  // ----------------------------------------------------------------
  logic [2:0] topLvl;
  logic [11:0] comLowD, sharedD;
  logic [47:0] segFixD;

  assign topLvl = bias4_q ? LVL_TOP4 : LVL_TOP3;
  // inverted frames mirror every level about mid-supply
  function automatic logic [2:0] lvl(input logic [2:0] l, input logic inv,
                                     input logic [2:0] top);
    lvl = inv ? top - l : l;
  endfunction

  function automatic logic [2:0] comLvl(input logic sel, input logic inv,
                                        input logic [2:0] top);
    comLvl = lvl(sel ? top : LVL_ONE, inv, top);
  endfunction

  function automatic logic [2:0] segLvl(input logic on, input logic inv,
                                        input logic [2:0] top);
    segLvl = lvl(on ? LVL_GND : LVL_TWO, inv, top);
  endfunction

  always_comb begin
    logic on;
    logic [7:0] b;
    on = 1'b0;
    b = 8'h00;
    comLowD = '0;
    sharedD = '0;
    segFixD = '0;
    if (drv_q == DRV_HOLD) begin
      // every output at the supply level
      for (int c = 0; c < 4; c++) begin
        comLowD[3*c +: 3] = topLvl;
        sharedD[3*c +: 3] = topLvl;
      end
      for (int s = 0; s < 16; s++) begin
        segFixD[3*s +: 3] = topLvl;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        comLowD[3*c +: 3] = comLvl(phase_q == 3'(c), frameInv_q, topLvl);
      end
      // shared pins commons 4-7 or segments 0-3
      // 20x4 map pairs segments per byte, 16x8 one per byte
      for (int c = 0; c < 4; c++) begin
        if (duty8_q) begin
          sharedD[3*c +: 3] = comLvl(phase_q == 3'(c + 4), frameInv_q, topLvl);
        end else begin
          b = dispRam_q[c / 2];
          on = b[4 * (c % 2) + int'(phase_q[1:0])] && !blinkBlank;
          sharedD[3*c +: 3] = segLvl(on, frameInv_q, topLvl);
        end
      end
      for (int s = 0; s < 16; s++) begin
        if (duty8_q) begin
          b = dispRam_q[s];
          on = b[phase_q];
        end else begin
          b = dispRam_q[(s + 4) / 2];
          on = b[4 * (s % 2) + int'(phase_q[1:0])];
        end
        segFixD[3*s +: 3] = segLvl(on && !blinkBlank, frameInv_q, topLvl);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      commonOutputsLow <= {4{LVL_TOP3}};
      sharedCommonSegmentOutputs <= {4{LVL_TOP3}};
      segmentOutputsFixed <= {16{LVL_TOP3}};
    end else begin
      commonOutputsLow <= comLowD;
      sharedCommonSegmentOutputs <= sharedD;
      segmentOutputsFixed <= segFixD;
    end
  end

  // ----------------------------------------------------------------
  // analogue control outputs
  // ----------------------------------------------------------------
  assign voltageAdjustCode = vadjCode_q;
  assign voltageAdjustEnable = vadjEn_q;
  assign lcdSupplyPinMode = pinSupply_q;
  assign detectSwitchClosed = detect_q;
  assign biasGenEnable = biasEn_q;
  assign oscRunning = oscEn_q;
endmodule
`default_nettype wire

// file: ldrcs_top_asserts.sv
// port-level checks for the lcd reset/config block
`timescale 1ns/1ps
`default_nettype none
module ldrcs_top_asserts
  import ldrcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [11:0] commonOutputsLow,
  input wire logic [11:0] sharedCommonSegmentOutputs,
  input wire logic [47:0] segmentOutputsFixed,
  input wire logic [3:0] voltageAdjustCode,
  input wire logic voltageAdjustEnable,
  input wire logic lcdSupplyPinMode,
  input wire logic detectSwitchClosed,
  input wire logic biasGenEnable,
  input wire logic oscRunning
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wrV, wrS, idle;
  logic [2:0] lv;
  assign wrV = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_VADJ;
  assign wrS = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_SYSMODE;
  assign idle = !oscRunning || !biasGenEnable;
  assign lv = commonOutputsLow[2:0];
  // ----
  // bus handshake
  // ----
  chk_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > REG_STATUS
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // ----
  // power-on state and drive hold
  // ----
  chk_reset_levels: assert property ($fell(sys_rst) |-> commonOutputsLow == 12'h6db
    && sharedCommonSegmentOutputs == 12'h6db && segmentOutputsFixed == 48'h6db6db6db6db)
    else $error("outputs not at supply level after reset");
  chk_reset_config: assert property ($fell(sys_rst)
    |-> voltageAdjustCode == 4'h0
    && voltageAdjustEnable && !lcdSupplyPinMode && !detectSwitchClosed
    && !biasGenEnable && !oscRunning)
    else $error("config outputs not at defaults after reset");
  // a mid-run reset reloads the defaults with no write behind it
  chk_vadj_cause: assert property ($changed({voltageAdjustCode, voltageAdjustEnable,
    lcdSupplyPinMode, detectSwitchClosed}) |-> $past(wrV) || $past(sys_rst))
    else $error("voltage settings changed without a write");
  chk_enable_cause: assert property ($changed({oscRunning, biasGenEnable})
    |-> $past(wrS) || $past(sys_rst))
    else $error("enables changed without a write");
  // oscillator or bias off: every pin sits at one common level of at least top-of-third
  // stop reaches the pins through the drive-state flop and the output flop
  chk_hold_uniform: assert property (idle && $past(idle) && $past(idle, 2)
    |-> lv >= LVL_TOP3
    && commonOutputsLow == {4{lv}} && sharedCommonSegmentOutputs == {4{lv}}
    && segmentOutputsFixed == {16{lv}})
    else $error("outputs move while drive is stopped");
  cover property (wb_ack_o && wb_we_i);
  cover property (wb_ack_o && !wb_we_i && wb_adr_i > REG_STATUS);
  cover property (!idle && lv != LVL_TOP3);
endmodule
bind ldrcs_top ldrcs_top_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .commonOutputsLow(commonOutputsLow),
  .sharedCommonSegmentOutputs(sharedCommonSegmentOutputs),
  .segmentOutputsFixed(segmentOutputsFixed), .voltageAdjustCode(voltageAdjustCode),
  .voltageAdjustEnable(voltageAdjustEnable), .lcdSupplyPinMode(lcdSupplyPinMode),
  .detectSwitchClosed(detectSwitchClosed), .biasGenEnable(biasGenEnable),
  .oscRunning(oscRunning));
`default_nettype wire

// file: ldrcs_host_model.sv
// host controller model: classic wishbone master for the config block
`timescale 1ns/1ps
`default_nettype none
module ldrcs_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ack,
  input wire logic [31:0] datR,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] datW
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    datW = 32'h0;
  end
  // call right after a rising edge; no wait bound, the bench watchdog cuts hangs
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
    // no traffic while power-on reset is held
    while (sys_rst) @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    sel <= s;
    // host programs settings through full handshakes
    do @(posedge clk); while (!ack);
    r = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    datW <= ~d;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the lcd reset/config block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ldrcs_pkg::*;
;
  logic clk, sys_rst, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel, vCode;
  logic [31:0] datW, datR, junk;
  logic [11:0] comLo, shared;
  logic [47:0] seg;
  logic vEn, pinMode, detClosed, biasEn, oscOn;
  int nErrors, nTests, n;
  // small clock rate gives 10 clocks per oscillator tick, 1000 per phase
  ldrcs_top #(.CLK_HZ(320000), .OSC_HZ(32000), .BLINK_DIV(16)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .commonOutputsLow(comLo), .sharedCommonSegmentOutputs(shared),
    .segmentOutputsFixed(seg), .voltageAdjustCode(vCode), .voltageAdjustEnable(vEn),
    .lcdSupplyPinMode(pinMode), .detectSwitchClosed(detClosed), .biasGenEnable(biasEn),
    .oscRunning(oscOn));
  ldrcs_host_model host_u (.clk(clk), .sys_rst(sys_rst), .ack(ack), .datR(datR), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .datW(datW));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----
  // helpers
  // ----
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, 4'h1, junk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    host_u.xfer(1'b0, a, 32'h0, 4'hf, r);
    check({16'h0, r}, {16'h0, exp});
  endtask
  task automatic defaults_chk();
    check({comLo, shared}, 24'h6db6db);
    check(seg, 48'h6db6db6db6db);
    check({vEn, vCode}, 5'h10);
    check({pinMode, detClosed, biasEn, oscOn}, 4'h0);
    rd_chk(REG_DRIVE, 32'h0);
    rd_chk(REG_SYSMODE, 32'h0);
    rd_chk(REG_FRAME, 32'h0);
    rd_chk(REG_BLINK, 32'h0);
    rd_chk(REG_VADJ, 32'h10);
  endtask
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    stopTest();
  end
  // ----
  // tests
  // ----
  initial begin
    sys_rst = 1'b1;
    nErrors = 0;
    nTests = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    defaults_chk();
    $display("test power_on_defaults done");
    for (int i = 0; i < 4; i++) begin
      wr(REG_DRIVE, 32'(i));
      rd_chk(REG_DRIVE, 32'(i));
      wr(REG_BLINK, 32'(i));
      rd_chk(REG_BLINK, 32'(i));
    end
    for (int i = 0; i < 2; i++) begin
      wr(REG_FRAME, 32'(i));
      rd_chk(REG_FRAME, 32'(i));
    end
    wr(REG_DRIVE, 32'h0);
    wr(REG_BLINK, 32'h0);
    wr(REG_FRAME, 32'h0);
    wr(REG_VADJ, 32'h7f);
    check({detClosed, pinMode, vEn, vCode}, 7'h7f);
    host_u.xfer(1'b1, REG_VADJ, 32'h10, 4'h0, junk);
    rd_chk(REG_VADJ, 32'h7f);
    wr(REG_VADJ, 32'h10);
    wr(8'h40, 32'hff);
    rd_chk(8'h40, 32'h0);
    $display("test settings done");
    wr(REG_ADDR, 32'hf);
    wr(REG_DATA, 32'ha5);
    wr(REG_DATA, 32'h01);
    wr(REG_ADDR, 32'hf);
    rd_chk(REG_DATA, 32'ha5);
    rd_chk(REG_DATA, 32'h01);
    $display("test pointer done");
    wr(REG_SYSMODE, 32'h3);
    repeat (20) @(posedge clk);
    check(comLo, 12'h6db);
    wr(REG_SYSMODE, 32'h7);
    repeat (3) @(posedge clk);
    // com0 selected at top, seg0 on at ground, others off
    check({comLo, shared}, 24'h24b490);
    check(seg, 48'h492492492492);
    n = 0;
    while (comLo[5:3] !== 3'h3 && n < 1500) begin
      @(posedge clk);
      n++;
    end
    // phase ends 1000 clocks after the oscillator write, the wait starts 27 clocks later
    check(n > 970 && n < 980, 1'b1);
    check(comLo[2:0], 3'h1);
    rd_chk(REG_STATUS, 32'h21);
    wr(REG_SYSMODE, 32'h6);
    repeat (2) @(posedge clk);
    check(comLo, 12'h6db);
    $display("test drive done");
    wr(REG_SYSMODE, 32'h7);
    wr(REG_VADJ, 32'h6f);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    defaults_chk();
    wr(REG_ADDR, 32'h0);
    rd_chk(REG_DATA, 32'h0);
    $display("test second_reset done");
    stopTest();
  end
endmodule
`default_nettype wire
